// file: bench/irq_source_model.sv
// Request sources and microcode program seen by the interrupt unit
`include "seq_irq_defines.vh"
`default_nettype none
module irq_source_model (
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic [7:0] fire_i,
    input  wire logic [3:0] prog_op_i,
    input  wire logic       prog_valid_i,
    input  wire logic       vector_valid_i,
    output logic      [7:0] request_line_o,
    output logic      [3:0] op_code_o,
    output logic            op_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic first_reg;
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            first_reg <= 1'b0;
            request_line_o <= 8'h00;
        end else begin
            first_reg <= vector_valid_i;
            request_line_o <= fire_i;
        end
    end
    // Routine entry slot always holds a continue
    assign op_code_o = first_reg ? `OP_CONTINUE : prog_op_i;
    assign op_valid_o = first_reg | prog_valid_i;
endmodule
`default_nettype wire

// file: bench/sequencer_interrupt_unit_assertions.sv
// Port checks for the sequencer interrupt unit
`include "seq_irq_defines.vh"
`default_nettype none
module seq_irq_checker (
    input wire logic        mclk_i,
    input wire logic        rstn_i,
    input wire logic        trap_i,
    input wire logic [3:0]  op_code_i,
    input wire logic        op_valid_i,
    input wire logic [15:0] data_i,
    input wire logic        vector_valid_o,
    input wire logic        push_o,
    input wire logic        pop_o,
    input wire logic        service_active_o,
    input wire logic        data_oe_o,
    input wire logic [15:0] status_word_o,
    input wire logic [3:0]  stack_limit_value_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    logic [2:0] quiet_cnt;
    logic       is_ret;
    assign is_ret = op_valid_i && op_code_i == `OP_RETURN_SVC;
    // Cycles with global enable off and no trap
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i)
            quiet_cnt <= 3'h0;
        else if (status_word_o[`ENABLE_BIT] || trap_i)
            quiet_cnt <= 3'h0;
        else if (quiet_cnt != 3'h7)
            quiet_cnt <= quiet_cnt + 3'h1;
    end
    chk_push_follows: assert property (vector_valid_o |=> push_o)
        else $error("no push after vector");
    chk_vec_active: assert property (vector_valid_o |-> service_active_o)
        else $error("vector without service active");
    chk_return_clears: assert property (is_ret |=> !service_active_o || vector_valid_o)
        else $error("service active kept after return");
    chk_return_pops: assert property (is_ret |=> pop_o)
        else $error("no pop after return");
    chk_disabled_quiet: assert property (quiet_cnt >= 3'h4 |-> !vector_valid_o)
        else $error("vector while disabled");
    chk_read_drives: assert property (op_valid_i && op_code_i == `OP_READ_VEC |=> data_oe_o)
        else $error("no data after vector read");
    chk_mask_set: assert property (op_valid_i && op_code_i == `OP_SET_MASK |=>
        (status_word_o & $past(data_i) & 16'hFFC0) == ($past(data_i) & 16'hFFC0))
        else $error("mask bits not set");
    chk_mask_clear: assert property (op_valid_i && op_code_i == `OP_CLR_MASK |=>
        (status_word_o & $past(data_i) & 16'hFFC0) == 16'h0000)
        else $error("mask bits not cleared");
    chk_limit_load: assert property (op_valid_i && op_code_i == `OP_LOAD_LIMIT_PTR |=>
        stack_limit_value_o == $past(data_i[15:12]))
        else $error("stack limit not loaded");
    cov_vector: cover property (vector_valid_o);
    cov_pop: cover property (pop_o);
    cov_read: cover property (data_oe_o);
endmodule
bind sequencer_interrupt_unit seq_irq_checker chk (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .trap_i(trap_i), .op_code_i(op_code_i),
    .op_valid_i(op_valid_i), .data_i(data_i), .vector_valid_o(vector_valid_o),
    .push_o(push_o), .pop_o(pop_o), .service_active_o(service_active_o),
    .data_oe_o(data_oe_o), .status_word_o(status_word_o),
    .stack_limit_value_o(stack_limit_value_o));
`default_nettype wire

// file: bench/tb_sequencer_interrupt_unit.sv
// Self-checking bench for the sequencer interrupt unit
`include "seq_irq_defines.vh"
`default_nettype none
module tb_sequencer_interrupt_unit;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_i = 1'b0, rstn_i = 1'b0, cs = 1'b0, trap = 1'b0, pv = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        ov, pready, pslverr, oe, vv, push, pop, act, er;
    logic [7:0]  fire = 8'h00, rq;
    logic [3:0]  po = 4'h0, oc, lim;
    logic [11:0] paddr = 12'h000;
    logic [15:0] dat = 16'h0000, pc = 16'h0000, dout, va, pa, stat;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int          mismatches = 0, checks = 0, cycles = 0;
    sequencer_interrupt_unit uut (.mclk_i(mclk_i), .rstn_i(rstn_i), .request_line_i(rq),
        .counter_sign_i(cs), .stack_fault_i(1'b0), .trap_i(trap), .op_code_i(oc),
        .op_valid_i(ov), .data_i(dat), .jump_due_i(1'b0), .jump_addr_i(16'h0000),
        .next_addr_i(pc), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .data_o(dout), .data_oe_o(oe), .vector_valid_o(vv), .vector_addr_o(va),
        .push_o(push), .push_addr_o(pa), .pop_o(pop), .service_active_o(act),
        .status_word_o(stat), .stack_limit_value_o(lim));
    irq_source_model model (.mclk_i(mclk_i), .rstn_i(rstn_i), .fire_i(fire), .prog_op_i(po),
        .prog_valid_i(pv), .vector_valid_i(vv), .request_line_o(rq), .op_code_o(oc),
        .op_valid_o(ov));
    always #12.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        pc <= pc + 16'h0001;
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches++;
            end_sim;
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task op(input logic [3:0] c, input logic [15:0] d);
        @(posedge mclk_i);
        po <= c;
        pv <= 1'b1;
        dat <= d;
        @(posedge mclk_i);
        pv <= 1'b0;
        #1;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        @(posedge mclk_i);
        while (pready !== 1'b1) @(posedge mclk_i);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task fire_req(input logic [7:0] m);
        @(posedge mclk_i);
        fire <= m;
        @(posedge mclk_i);
        fire <= 8'h00;
    endtask
    task wait_vec(input logic [15:0] e);
        for (int i = 0; i < 8 && vv !== 1'b1; i++) begin
            @(posedge mclk_i);
            #1;
        end
        check({vv, va}, {1'b1, e});
        @(posedge mclk_i);
        #1;
        check(push, 1'b1);
        check(pa, pc - 16'h0002);
    endtask
    task no_vec(input int n);
        repeat (n) begin
            @(posedge mclk_i);
            #1;
            check(vv, 1'b0);
        end
    endtask
    task t_vec;
        check(stat, 16'hFFC0);
        apb(1'b0, 12'h020, 32'h0);
        check(er, 1'b1);
        apb(1'b1, `APB_LIMIT, 32'h9);
        apb(1'b0, `APB_LIMIT, 32'h0);
        check(rd, 32'h9);
        op(`OP_CLR_ENABLE, 16'h0000);
        op(`OP_LOAD_PTR, 16'h0000);
        for (int i = 0; i < 10; i++) op(`OP_WRITE_VEC, 16'h0A00 + i[15:0]);
        apb(1'b0, `APB_POINTER, 32'h0);
        check(rd, 32'hA);
        op(`OP_LOAD_LIMIT_PTR, 16'h5000);
        apb(1'b0, `APB_LIMIT, 32'h0);
        check(rd, 32'h5);
        for (int i = 0; i < 10; i++) begin
            op(`OP_READ_VEC, 16'h0000);
            check({oe, dout}, {1'b1, 16'h0A00 + i[15:0]});
        end
        $display("vector file test done");
    endtask
    task t_prio;
        op(`OP_CLR_MASK, 16'hFFC0);
        op(`OP_SET_ENABLE, 16'h0004);
        check(stat, 16'h0004);
        fire_req(8'h82);
        wait_vec(16'h0A08);
        op(`OP_RETURN_SVC, 16'h0000);
        check(pop, 1'b1);
        wait_vec(16'h0A02);
        op(`OP_RETURN_SVC, 16'h0000);
        fork
            fire_req(8'h01);
            begin
                @(posedge mclk_i);
                op(`OP_SET_MASK, 16'h0080);
            end
        join
        wait_vec(16'h0A01);
        op(`OP_RETURN_SVC, 16'h0000);
        fire_req(8'h01);
        no_vec(6);
        op(`OP_CLR_MASK, 16'h0080);
        wait_vec(16'h0A01);
        op(`OP_RETURN_SVC, 16'h0000);
        $display("priority and mask test done");
    endtask
    task t_nest;
        fire_req(8'h0C);
        wait_vec(16'h0A04);
        no_vec(6);
        op(`OP_CLR_CURRENT, 16'h0000);
        wait_vec(16'h0A03);
        @(posedge mclk_i);
        trap <= 1'b1;
        @(posedge mclk_i);
        trap <= 1'b0;
        wait_vec(16'h0A09);
        op(`OP_RETURN_SVC, 16'h0000);
        check(act, 1'b0);
        wait_vec(16'h0A03);
        op(`OP_CLR_ALL, 16'h0000);
        check(act, 1'b0);
        no_vec(6);
        apb(1'b0, `APB_LATCH, 32'h0);
        check(rd & 32'h1FE, 32'h0);
        $display("nesting test done");
    endtask
    task t_ctr;
        @(posedge mclk_i);
        cs <= 1'b1;
        wait_vec(16'h0A00);
        check(stat[`UNDERFLOW_BIT], 1'b1);
        op(`OP_RETURN_SVC, 16'h0000);
        wait_vec(16'h0A00);
        op(`OP_CLR_UNDERFLOW, 16'h0000);
        op(`OP_RETURN_SVC, 16'h0000);
        no_vec(6);
        check(stat[`UNDERFLOW_BIT], 1'b0);
        $display("counter test done");
    endtask
    initial begin
        repeat (4) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(posedge mclk_i);
        #1;
        t_vec;
        t_prio;
        t_nest;
        t_ctr;
        end_sim;
    end
endmodule
`default_nettype wire

// file: core/sequencer_interrupt_unit.v
// Interrupt request, vector file and service control for a microprogram sequencer
// Functional notes
// RULE1 - Ten requests: eight external, two internal, each with its own vector entry.
// RULE2 - Load-pointer op sets 4-bit slot pointer; read/write ops move entry over data.
// RULE3 - Slot pointer increments by one after every vector read or write.
// RULE4 - Program should disable interrupts before touching the vector file.
// RULE5 - Simultaneous requests served highest number first, request nine first.
// RULE6 - Status bits 15..6 mask requests 9..0; masked requests stay latched.
// RULE7 - One op sets, another clears, any mask bits chosen by data word.
// RULE8 - Status bit 2 enables globally; disabled requests still latch.
// RULE9 - Pending request unmasked or enabled gets vector one cycle after that op; this unit outputs it two cycles after.
// RULE10 - Request latched with a masking op is still taken; one later waits.
// RULE11 - Return address pushed one cycle after vector, during first routine cycle.
// RULE12 - Each service routine begins with a continue op.
// RULE13 - Service start sets service_active; it blocks other maskable requests.
// RULE14 - Return pops address, clears service_active, clears external latch 8..1.
// RULE15 - Internal requests nine and zero survive return; only own ops clear them.
// RULE16 - Clear-current op clears service_active and current external latch.
// RULE17 - Clear-all op clears service_active and all external latches only.
// RULE18 - Pending request seen during clear ops; vector output the following cycle.
// RULE19 - Trap ignores service_active; returning from trap clears service_active.
// RULE20 - Request pending at return gets vector one cycle after the return.
// RULE21 - Vector displaces a due jump address, which is pushed as return address.
// RULE22 - Counter sign rising raises request zero; clear-underflow clears it and status.
// RULE23 - Stack fault raises request nine until load-limit-and-pointer op.
// RULE24 - Trap uses the vector entry of request nine.
// RULE25 - External lines latched on the clock until a return or clear op.
`include "seq_irq_defines.vh"
`default_nettype none

module sequencer_interrupt_unit #(
    parameter NUM_REQ = `NUM_REQ,
    parameter ADDR_W  = `ADDR_W,
    parameter PTR_W   = `PTR_W
) (
    input  wire                mclk_i,
    input  wire                rstn_i,
    input  wire [7:0]          request_line_i,
    input  wire                counter_sign_i,
    input  wire                stack_fault_i,
    input  wire                trap_i,
    input  wire [3:0]          op_code_i,
    input  wire                op_valid_i,
    input  wire [15:0]         data_i,
    input  wire                jump_due_i,
    input  wire [ADDR_W-1:0]   jump_addr_i,
    input  wire [ADDR_W-1:0]   next_addr_i,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [11:0]         paddr,
    input  wire [31:0]         pwdata,
    input  wire [3:0]          pstrb,
    output reg  [31:0]         prdata,
    output reg                 pready,
    output reg                 pslverr,
    output reg  [15:0]         data_o,
    output reg                 data_oe_o,
    output reg                 vector_valid_o,
    output reg  [ADDR_W-1:0]   vector_addr_o,
    output reg                 push_o,
    output reg  [ADDR_W-1:0]   push_addr_o,
    output reg                 pop_o,
    output reg                 service_active_o,
    output reg  [15:0]         status_word_o,
    output reg  [3:0]          stack_limit_value_o
);

    reg [ADDR_W-1:0]  vector_file_reg [0:NUM_REQ-1];
    reg [PTR_W-1:0]   vector_slot_pointer_reg;
    reg [NUM_REQ-1:0] latch_reg;
    reg [15:0]        status_word_reg;
    reg               service_active_reg;
    reg [3:0]         current_reg;
    reg               take_reg;
    reg [3:0]         take_idx_reg;
    reg [ADDR_W-1:0]  ret_addr_reg;
    reg               push_pend_reg;
    reg               sign_reg;
    reg               trap_pend_reg;
    reg [ADDR_W-1:0]  trap_ret_reg;

    wire op_load   = op_valid_i && (op_code_i == `OP_LOAD_PTR);
    wire op_rd     = op_valid_i && (op_code_i == `OP_READ_VEC);
    wire op_wr     = op_valid_i && (op_code_i == `OP_WRITE_VEC);
    wire op_setm   = op_valid_i && (op_code_i == `OP_SET_MASK);
    wire op_clrm   = op_valid_i && (op_code_i == `OP_CLR_MASK);
    wire op_sete   = op_valid_i && (op_code_i == `OP_SET_ENABLE);
    wire op_clre   = op_valid_i && (op_code_i == `OP_CLR_ENABLE);
    wire op_ret    = op_valid_i && (op_code_i == `OP_RETURN_SVC);
    wire op_ccur   = op_valid_i && (op_code_i == `OP_CLR_CURRENT);
    wire op_call   = op_valid_i && (op_code_i == `OP_CLR_ALL);
    wire op_clru   = op_valid_i && (op_code_i == `OP_CLR_UNDERFLOW);
    wire op_limit  = op_valid_i && (op_code_i == `OP_LOAD_LIMIT_PTR);

    wire apb_wr = psel && penable && pwrite && pready;
    wire apb_sel_limit = (paddr == `APB_LIMIT);

    // Highest numbered set bit
    function [4:0] top_req;
        input [NUM_REQ-1:0] v;
        integer k;
        begin
            top_req = 5'h10;
            for (k = 0; k < NUM_REQ; k = k + 1) begin
                if (v[k]) begin
                    top_req = k[4:0];
                end
            end
        end
    endfunction

    // Counter underflow edge
    wire sign_rise = counter_sign_i && !sign_reg; // RULE22

    // New requests this cycle
    wire [NUM_REQ-1:0] raise = {stack_fault_i, request_line_i, sign_rise}; // RULE1 RULE25

    // Masks and enable as of the previous cycle, so a request latched alongside a
    // masking op is still seen, while the unmask shows one cycle after its op.
    wire [NUM_REQ-1:0] mask = status_word_reg[`MASK_MSB:`MASK_LSB]; // RULE6
    wire               gen  = status_word_reg[`ENABLE_BIT]; // RULE8
    // Clear ops reopen arbitration in the same cycle
    wire lockout = service_active_reg && !op_ret && !op_ccur && !op_call; // RULE13 RULE18 RULE20
    // Latches cleared this cycle must not win the arbitration reopened by the clear
    wire cur_ext = (op_ret || op_ccur) && current_reg >= 4'h1 && current_reg <= 4'h8;
    wire [NUM_REQ-1:0] clr_now =
        ({{(NUM_REQ-1){1'b0}}, cur_ext} << current_reg) | // RULE14 RULE16
        {{(NUM_REQ-9){1'b0}}, {8{op_call}}, 1'b0} | // RULE17 RULE15
        {{(NUM_REQ-1){1'b0}}, op_clru} | // RULE22
        {op_limit, {(NUM_REQ-1){1'b0}}}; // RULE23
    wire [NUM_REQ-1:0] eligible = ((latch_reg & ~clr_now) | raise) & ~mask; // RULE10 RULE20
    wire [4:0] win = top_req(eligible); // RULE5
    wire grant = gen && !lockout && !win[4] && !take_reg; // RULE8 RULE9
    wire trap_go = trap_i && !take_reg; // RULE19

    integer i;

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (i = 0; i < NUM_REQ; i = i + 1) begin
                vector_file_reg[i] <= `VECTOR_RESET;
            end
            vector_slot_pointer_reg <= {PTR_W{1'b0}};
            latch_reg               <= {NUM_REQ{1'b0}};
            status_word_reg         <= `STATUS_RESET;
            service_active_reg      <= 1'b0;
            current_reg             <= 4'h0;
            take_reg                <= 1'b0;
            take_idx_reg            <= 4'h0;
            ret_addr_reg            <= {ADDR_W{1'b0}};
            push_pend_reg           <= 1'b0;
            sign_reg                <= 1'b0;
            trap_pend_reg           <= 1'b0;
            trap_ret_reg            <= {ADDR_W{1'b0}};
            stack_limit_value_o     <= 4'h0;
            data_o                  <= 16'h0000;
            data_oe_o               <= 1'b0;
            vector_valid_o          <= 1'b0;
            vector_addr_o           <= {ADDR_W{1'b0}};
            push_o                  <= 1'b0;
            push_addr_o             <= {ADDR_W{1'b0}};
            pop_o                   <= 1'b0;
            service_active_o        <= 1'b0;
            status_word_o           <= `STATUS_RESET;
        end else begin
            sign_reg <= counter_sign_i;

            // Vector file and slot pointer
            if (op_load || op_limit) begin
                vector_slot_pointer_reg <= data_i[PTR_W-1:0]; // RULE2 RULE23
            end else if (op_rd || op_wr) begin
                vector_slot_pointer_reg <= vector_slot_pointer_reg + 1'b1; // RULE3
            end
            if (op_wr && vector_slot_pointer_reg < NUM_REQ) begin
                vector_file_reg[vector_slot_pointer_reg] <= data_i[ADDR_W-1:0]; // RULE2
            end
            data_oe_o <= op_rd;
            if (op_rd) begin
                data_o <= (vector_slot_pointer_reg < NUM_REQ) ?
                          vector_file_reg[vector_slot_pointer_reg] : 16'h0000; // RULE2
            end
            if (op_limit) begin
                stack_limit_value_o <= data_i[15:12];
            end else if (apb_wr && apb_sel_limit && pstrb[0]) begin
                stack_limit_value_o <= pwdata[3:0];
            end

            // Status word: masks, enable, underflow flag
            begin : status_upd
                reg [15:0] s;
                s = status_word_reg;
                if (op_setm) begin
                    s[`MASK_MSB:`MASK_LSB] = s[`MASK_MSB:`MASK_LSB] | data_i[15:6]; // RULE7
                end
                if (op_clrm) begin
                    s[`MASK_MSB:`MASK_LSB] = s[`MASK_MSB:`MASK_LSB] & ~data_i[15:6]; // RULE7
                end
                if (op_sete) begin
                    s[`ENABLE_BIT] = 1'b1; // RULE8
                end
                if (op_clre) begin
                    s[`ENABLE_BIT] = 1'b0; // RULE8
                end
                if (apb_wr && paddr == `APB_STATUS) begin
                    if (pstrb[0]) s[7:0] = pwdata[7:0];
                    if (pstrb[1]) s[15:8] = pwdata[15:8];
                end
                if (op_clru) begin
                    s[`UNDERFLOW_BIT] = 1'b0; // RULE22
                end
                if (sign_rise) begin
                    s[`UNDERFLOW_BIT] = 1'b1; // RULE22
                end
                status_word_reg <= s;
                status_word_o   <= s;
            end

            // Request latches; new events win over clears
            latch_reg <= (latch_reg & ~clr_now) | raise; // RULE25

            // Vector output the cycle after recognition; displaced jump is saved
            vector_valid_o <= 1'b0;
            take_reg       <= 1'b0;
            if (trap_go || grant) begin
                take_reg     <= 1'b1;
                take_idx_reg <= trap_go ? 4'd`REQ_TRAP : win[3:0]; // RULE24
                trap_pend_reg <= trap_go;
                trap_ret_reg  <= jump_due_i ? jump_addr_i : next_addr_i;
            end
            if (take_reg) begin
                vector_valid_o <= 1'b1;
                vector_addr_o  <= vector_file_reg[take_idx_reg]; // RULE1
                ret_addr_reg   <= jump_due_i ? jump_addr_i : next_addr_i; // RULE21
                current_reg    <= take_idx_reg;
            end

            // Push one cycle after vector output
            push_pend_reg <= take_reg;
            push_o        <= push_pend_reg; // RULE11
            if (push_pend_reg) begin
                push_addr_o <= ret_addr_reg; // RULE11 RULE21
            end

            // Service-active flag; a new start wins over a clear
            if (take_reg) begin
                service_active_reg <= 1'b1; // RULE13
            end else if (op_ret || op_ccur || op_call) begin
                service_active_reg <= 1'b0; // RULE14 RULE16 RULE17 RULE19
            end
            service_active_o <= take_reg ? 1'b1 :
                                ((op_ret || op_ccur || op_call) ? 1'b0 : service_active_reg);
            pop_o <= op_ret; // RULE14
        end
    end

    // APB slave, one wait state
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= 1'b0;
            if (psel && penable && !pready) begin
                prdata <= 32'h00000000;
                case (paddr)
                    `APB_STATUS:  prdata <= {16'h0000, status_word_reg};
                    `APB_LATCH:   prdata <= {22'h000000, latch_reg};
                    `APB_POINTER: prdata <= {28'h0000000, vector_slot_pointer_reg};
                    `APB_CURRENT: prdata <= {27'h0000000, service_active_reg, current_reg};
                    `APB_LIMIT:   prdata <= {28'h0000000, stack_limit_value_o};
                    default:      pslverr <= 1'b1;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// file: include/seq_irq_defines.vh
// Constants for the sequencer interrupt unit
`ifndef SEQ_IRQ_DEFINES_VH
`define SEQ_IRQ_DEFINES_VH
`define NUM_REQ           10
`define ADDR_W            16
`define PTR_W             4
`define MASK_LSB          6
`define MASK_MSB          15
`define ENABLE_BIT        2
`define UNDERFLOW_BIT     1
`define REQ_TRAP          9
`define REQ_COUNTER       0
`define STATUS_RESET      16'hFFC0
`define VECTOR_RESET      16'h0000
`define OP_NONE           4'h0
`define OP_LOAD_PTR       4'h1
`define OP_READ_VEC       4'h2
`define OP_WRITE_VEC      4'h3
`define OP_SET_MASK       4'h4
`define OP_CLR_MASK       4'h5
`define OP_SET_ENABLE     4'h6
`define OP_CLR_ENABLE     4'h7
`define OP_RETURN_SVC     4'h8
`define OP_CLR_CURRENT    4'h9
`define OP_CLR_ALL        4'hA
`define OP_CLR_UNDERFLOW  4'hB
`define OP_LOAD_LIMIT_PTR 4'hC
`define OP_CONTINUE       4'hD
`define APB_STATUS        12'h000
`define APB_LATCH         12'h004
`define APB_POINTER       12'h008
`define APB_CURRENT       12'h00C
`define APB_LIMIT         12'h010
`endif
